/* verilog/see_pkg.sv */
// constants shared by both ends of the serial eeprom link
// assumes a 100 MHz system clock on each end and one bus master

package see_pkg;

    // ==========================================================
    // control byte decode
    localparam logic [3:0] TYPE_ARRAY    = 4'hA;  // normal array access
    localparam logic [3:0] TYPE_LOCK     = 4'h6;  // protection commands
    localparam logic [2:0] SEL_SET_REV   = 3'h1;  // select bits, set reversible
    localparam logic [2:0] SEL_CLR_REV   = 3'h3;  // select bits, clear reversible
    localparam logic [1:0] STRAP_SET_REV = 2'h0;  // upper straps for set
    localparam logic [1:0] STRAP_CLR_REV = 2'h1;  // upper straps for clear

    // ==========================================================
    // array layout
    localparam logic [7:0] PROT_TOP = 8'h7F;  // last word covered by software locks
    localparam logic [7:0] ERASED   = 8'hFF;  // filler for lock status reads
    localparam logic [2:0] BIT_LAST = 3'h7;   // eighth bit of a byte

    // ==========================================================
    // timing
    localparam int         CLK_NS    = 10;               // system clock period
    localparam int         PH_NS     = 40;               // quarter of a link clock
    localparam logic [1:0] PH_LAST   = 2'(PH_NS / CLK_NS - 1);
    localparam logic [7:0] RST_HOLD  = 8'h80;            // device reset stretch, cycles

    // ==========================================================
    // host command kinds
    localparam logic [1:0] K_WRITE = 2'h0;  // control, address, one data byte
    localparam logic [1:0] K_CUR   = 2'h1;  // control with read bit, then bytes
    localparam logic [1:0] K_RAND  = 2'h2;  // dummy write, restart, read bytes

endpackage : see_pkg

/* verilog/see_link_if.sv */
// two-wire link between the bus master and the eeprom end
// assumes the master alone drives the clock; data is open drain

interface see_link_if;
    logic scl;          // link clock, pushed by the master
    logic host_sda_o;   // master data out, always low
    logic host_sda_oe;  // master pulls data low
    logic dev_sda_o;    // device data out, always low
    logic dev_sda_oe;   // device pulls data low
    logic sda;          // resolved wire level

    // ==========================================================
    // wired-and with pull-up
    assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

    modport host (output scl, output host_sda_o, output host_sda_oe, input sda);
    modport dev  (input scl, output dev_sda_o, output dev_sda_oe, input sda);
endinterface : see_link_if

/* verilog/see_host.sv */
// two-wire bus master: writes, current and random reads
// assumes a free-running link clock is acceptable to the slave

module see_host (
    // system
    input  wire logic       I_CLK,
    input  wire logic       I_SYS_RST,
    // command
    input  wire logic       I_REQ,
    input  wire logic [1:0] I_KIND,
    input  wire logic [6:0] I_DEV,
    input  wire logic [7:0] I_ADDR,
    input  wire logic [7:0] I_WDATA,
    input  wire logic [7:0] I_COUNT,
    // answer
    output logic            O_BUSY,
    output logic            O_NACK,
    output logic            O_DONE,
    output logic            O_RD_VALID,
    output logic [7:0]      O_RD_DATA,
    // link
    see_link_if.host        link
);
    typedef enum logic [2:0] {
        H_IDLE, H_START, H_WBIT, H_WACK, H_RBIT, H_RACK, H_STOP
    } seh_st_t;

    typedef struct packed {
        seh_st_t    st;
        logic [1:0] stage;
        logic [2:0] cnt;
        logic [7:0] sh;
        logic [7:0] left;
        logic [1:0] kind;
        logic [6:0] dev;
        logic [7:0] addr;
        logic [7:0] wdata;
        logic [1:0] div;
        logic [1:0] phase;
        logic       scl;
        logic       oe;
        logic       busy;
        logic       nack;
        logic       done;
        logic       rd_valid;
        logic [7:0] rd_data;
        logic [1:0] sda_s;
    } seh_state_t;

    seh_state_t s_q;
    seh_state_t s_d;
    logic       sda_in;
    logic [1:0] ph_n;

    localparam logic [1:0] PH_LAST_L  = see_pkg::PH_LAST;
    localparam logic [1:0] K_CUR_L    = see_pkg::K_CUR;
    localparam logic [1:0] K_WRITE_L  = see_pkg::K_WRITE;
    localparam logic [2:0] BIT_LAST_L = see_pkg::BIT_LAST;

    // ==========================================================
    // sequencer: data moves at phase 1, samples and edges at phase 3
    always_comb begin
        s_d          = s_q;
        s_d.done     = 1'b0;
        s_d.rd_valid = 1'b0;
        s_d.sda_s    = {s_q.sda_s[0], link.sda};  // wire is async to us
        sda_in       = s_q.sda_s[1];
        ph_n         = s_q.phase + 2'h1;
        s_d.div      = (s_q.div == PH_LAST_L) ? 2'h0 : s_q.div + 2'h1;
        if (s_q.div == PH_LAST_L) begin
            s_d.phase = ph_n;
            s_d.scl   = ph_n[1];  // clock runs free, even when idle
            if (ph_n == 2'h1) begin
                unique case (s_q.st)
                    H_IDLE, H_START, H_WACK, H_RBIT: s_d.oe = 1'b0;
                    H_WBIT: s_d.oe = ~s_q.sh[7];
                    H_RACK: s_d.oe = (s_q.left != 8'h01);
                    H_STOP: s_d.oe = 1'b1;
                endcase
            end
            if (ph_n == 2'h3) begin
                unique case (s_q.st)
                    H_IDLE: ;
                    H_START: begin
                        s_d.oe  = 1'b1;  // falls while clock is high
                        // direction bit set only for the read leg
                        s_d.sh  = {s_q.dev, (s_q.kind == K_CUR_L) | (s_q.stage != 2'h0)};
                        s_d.cnt = 3'h0;
                        s_d.st  = H_WBIT;
                    end
                    H_WBIT: begin
                        s_d.sh  = {s_q.sh[6:0], 1'b0};
                        s_d.cnt = s_q.cnt + 3'h1;
                        if (s_q.cnt == BIT_LAST_L) begin
                            s_d.st = H_WACK;
                        end
                    end
                    H_WACK: begin
                        s_d.cnt   = 3'h0;
                        s_d.stage = s_q.stage + 2'h1;
                        if (sda_in) begin
                            s_d.nack = 1'b1;  // refused: just stop
                            s_d.st   = H_STOP;
                        end else if (s_q.kind == K_CUR_L) begin
                            s_d.st = H_RBIT;
                        end else if (s_q.stage == 2'h0) begin
                            s_d.sh = s_q.addr;
                            s_d.st = H_WBIT;
                        end else if (s_q.kind == K_WRITE_L) begin
                            s_d.sh = s_q.wdata;
                            s_d.st = (s_q.stage == 2'h1) ? H_WBIT : H_STOP;
                        end else begin
                            // word address only, then restart
                            s_d.st = (s_q.stage == 2'h1) ? H_START : H_RBIT;
                        end
                    end
                    H_RBIT: begin
                        s_d.sh  = {s_q.sh[6:0], sda_in};
                        s_d.cnt = s_q.cnt + 3'h1;
                        if (s_q.cnt == BIT_LAST_L) begin
                            s_d.st = H_RACK;
                        end
                    end
                    H_RACK: begin
                        s_d.rd_valid = 1'b1;
                        s_d.rd_data  = s_q.sh;
                        s_d.left     = s_q.left - 8'h01;
                        s_d.cnt      = 3'h0;
                        // last byte left unacknowledged, then stop
                        s_d.st       = (s_q.left == 8'h01) ? H_STOP : H_RBIT;
                    end
                    H_STOP: begin
                        s_d.oe   = 1'b0;  // rises while clock is high
                        s_d.busy = 1'b0;
                        s_d.done = 1'b1;
                        s_d.st   = H_IDLE;
                    end
                endcase
            end
        end
        // take a command only when idle
        if (I_REQ && !s_q.busy && s_q.st == H_IDLE) begin
            s_d.busy  = 1'b1;
            s_d.nack  = 1'b0;
            s_d.stage = 2'h0;
            s_d.kind  = I_KIND;
            s_d.dev   = I_DEV;
            s_d.addr  = I_ADDR;
            s_d.wdata = I_WDATA;
            s_d.left  = (I_COUNT == 8'h00) ? 8'h01 : I_COUNT;
            s_d.st    = H_START;
        end
    end

    // ==========================================================
    // state register
    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign link.scl         = s_q.scl;
    assign link.host_sda_o  = 1'b0;
    assign link.host_sda_oe = s_q.oe;
    assign O_BUSY           = s_q.busy;
    assign O_NACK           = s_q.nack;
    assign O_DONE           = s_q.done;
    assign O_RD_VALID       = s_q.rd_valid;
    assign O_RD_DATA        = s_q.rd_data;

endmodule : see_host

/* verilog/see_dev.sv */
// eeprom end of the two-wire link: 256-byte array, reads, lock commands
// assumes the link clock runs on between frames, as the master here does
// Function
// - protect pin high: array acked, reads work, writes dropped
// - protect pin high: lock set acked, no change
// - protect pin high: reversible clear acked, no change
// - permanent lock refuses its query, set, reversible clear
// - unlocked permanent query acked, data meaningless
// - reversible lock refuses its query and set
// - unlocked reversible query acked, data meaningless
// - master reads start like writes, direction one
// - address counter holds last access plus one
// - read counter wraps from last to first byte
// - current read: ack, send byte at counter
// - random read: dummy write, restart, read address
// - random read: ack, send addressed byte
// - master ack: advance counter, send next byte
// - sequential read wraps to zero without pause
// - master nack ends read; release data line
// - lock query: ack unprogrammed, no ack programmed
// - permanent lock guards lower half forever; here cleared by system reset
// - reversible lock guards lower half until cleared
// - type 1010 array, type 0110 lock command
// - software locks lower half, pin whole array
// - protected write acked, data discarded

module see_dev (
    // system
    input  wire logic       I_CLK,
    input  wire logic       I_SYS_RST,
    // straps and protect pin
    input  wire logic       I_WP,
    input  wire logic [2:0] I_STRAP,
    input  wire logic       I_HV,
    // lock status, system clock domain
    output logic            O_PERM_LOCKED,
    output logic            O_REV_LOCKED,
    // link
    see_link_if.dev         link
);
    typedef enum logic [3:0] {
        D_IDLE, D_CTRL, D_CACK, D_ADDR, D_AACK, D_WDATA, D_WACK, D_TX, D_TXACK
    } sed_st_t;

    typedef enum logic [2:0] {
        C_ARRAY, C_PQ, C_PSET, C_RQ, C_RSET, C_RCLR
    } sed_cmd_t;

    typedef struct packed {
        sed_st_t    st;
        sed_cmd_t   cmd;
        logic [2:0] cnt;
        logic [7:0] sh;
        logic [7:0] ctr;
        logic       oe;
        logic       perm;
        logic       rev;
        logic [1:0] wp_s;
        logic [5:0] strap_s;
        logic [1:0] hv_s;
    } sed_state_t;

    sed_state_t s_q;
    sed_state_t s_d;
    logic [7:0] mem [0:255];
    logic       sda_pos_q;
    logic [1:0] rst_s_q;
    logic [7:0] hold_q;
    logic       hold_act_q;
    logic [3:0] stat_s_q;

    logic       bit_in;
    logic       start;
    logic       stop;
    logic       last;
    logic       wp;
    logic [2:0] strap;
    logic       hv;
    logic       prot;
    logic [7:0] byte_in;
    logic [7:0] nxt;
    logic       dec_ok;
    sed_cmd_t   dec_cmd;
    logic       mem_we;

    // ==========================================================
    // reset stretch: the link domain needs its own edges to see it
    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            hold_q     <= see_pkg::RST_HOLD;
            hold_act_q <= 1'b1;
        end else begin
            hold_q     <= (hold_q != 8'h00) ? hold_q - 8'h01 : 8'h00;
            hold_act_q <= (hold_q != 8'h00);
        end
    end

    // lock status back to the system clock, two flops
    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            stat_s_q <= 4'h0;
        end else begin
            stat_s_q <= {stat_s_q[1:0], s_q.perm, s_q.rev};
        end
    end

    assign O_PERM_LOCKED = stat_s_q[3];
    assign O_REV_LOCKED  = stat_s_q[2];

    // ==========================================================
    // link side: data sampled on the rising clock, all else on the falling
    always_ff @(posedge link.scl) begin
        sda_pos_q <= link.sda;
    end

    always_ff @(negedge link.scl) begin
        rst_s_q <= {rst_s_q[0], hold_act_q};
    end

    // ==========================================================
    // decode of the received byte and next read byte
    always_comb begin
        bit_in  = sda_pos_q;
        // a data change while the clock was high marks start or stop
        start   = sda_pos_q & ~link.sda;
        stop    = ~sda_pos_q & link.sda;
        last    = (s_q.cnt == see_pkg::BIT_LAST);
        wp      = s_q.wp_s[1];
        strap   = s_q.strap_s[5:3];
        hv      = s_q.hv_s[1];
        byte_in = {s_q.sh[6:0], bit_in};
        // pin guards everything, locks only the lower half
        prot    = wp | ((s_q.perm | s_q.rev) & (s_q.ctr <= see_pkg::PROT_TOP));
        nxt     = (s_q.cmd == C_ARRAY) ? mem[s_q.ctr] : see_pkg::ERASED;
        dec_ok  = 1'b0;
        dec_cmd = C_ARRAY;
        if (byte_in[7:4] == see_pkg::TYPE_ARRAY && byte_in[3:1] == strap) begin
            dec_ok = 1'b1;
        end else if (byte_in[7:4] == see_pkg::TYPE_LOCK) begin
            if (!hv && byte_in[3:1] == strap) begin
                dec_cmd = byte_in[0] ? C_PQ : C_PSET;
                dec_ok  = ~s_q.perm;
            end else if (hv && byte_in[3:1] == see_pkg::SEL_SET_REV
                         && strap[2:1] == see_pkg::STRAP_SET_REV) begin
                dec_cmd = byte_in[0] ? C_RQ : C_RSET;
                dec_ok  = ~s_q.rev;
            end else if (hv && !byte_in[0] && byte_in[3:1] == see_pkg::SEL_CLR_REV
                         && strap[2:1] == see_pkg::STRAP_CLR_REV) begin
                dec_cmd = C_RCLR;
                dec_ok  = ~s_q.perm;
            end
        end
    end

    // ==========================================================
    // protocol engine; ack and data change right after the falling clock
    always_comb begin
        s_d         = s_q;
        mem_we      = 1'b0;
        s_d.wp_s    = {s_q.wp_s[0], I_WP};
        s_d.strap_s = {s_q.strap_s[2:0], I_STRAP};
        s_d.hv_s    = {s_q.hv_s[0], I_HV};
        if (stop) begin
            s_d.st = D_IDLE;
            s_d.oe = 1'b0;
        end else if (start) begin
            s_d.st  = D_CTRL;
            s_d.cnt = 3'h0;
            s_d.oe  = 1'b0;
        end else begin
            unique case (s_q.st)
                D_IDLE: ;
                D_CTRL, D_ADDR, D_WDATA: begin
                    s_d.sh  = byte_in;
                    s_d.cnt = s_q.cnt + 3'h1;
                    if (last) begin
                        s_d.oe = 1'b1;
                        if (s_q.st == D_CTRL) begin
                            s_d.cmd = dec_cmd;
                            s_d.oe  = dec_ok;
                            // refused: line left free until a new start
                            s_d.st  = dec_ok ? D_CACK : D_IDLE;
                        end else if (s_q.st == D_ADDR) begin
                            s_d.st = D_AACK;
                            if (s_q.cmd == C_ARRAY) begin
                                s_d.ctr = byte_in;
                            end
                        end else begin
                            s_d.st = D_WACK;  // acked even when dropped
                            unique case (s_q.cmd)
                                C_ARRAY: begin
                                    mem_we  = ~prot;
                                    // writes roll within a 16-byte page
                                    s_d.ctr = {s_q.ctr[7:4], s_q.ctr[3:0] + 4'h1};
                                end
                                C_PSET: s_d.perm = s_q.perm | ~wp;
                                C_RSET: s_d.rev  = s_q.rev | ~wp;
                                C_RCLR: s_d.rev  = s_q.rev & wp;
                                C_PQ, C_RQ: ;
                            endcase
                        end
                    end
                end
                D_CACK, D_TXACK: begin
                    s_d.cnt = 3'h0;
                    if (s_q.st == D_CACK && !s_q.sh[0]) begin
                        s_d.oe = 1'b0;
                        s_d.st = D_ADDR;
                    end else if (s_q.st == D_CACK || !bit_in) begin
                        // byte at counter; counter wraps at the top
                        s_d.sh = nxt;
                        s_d.oe = ~nxt[7];
                        s_d.st = D_TX;
                        if (s_q.cmd == C_ARRAY) begin
                            s_d.ctr = s_q.ctr + 8'h01;
                        end
                    end else begin
                        s_d.oe = 1'b0;  // master declined: stop driving
                        s_d.st = D_IDLE;
                    end
                end
                D_AACK, D_WACK: begin
                    s_d.oe  = 1'b0;
                    s_d.cnt = 3'h0;
                    s_d.st  = D_WDATA;
                end
                D_TX: begin
                    s_d.sh  = {s_q.sh[6:0], 1'b1};
                    s_d.cnt = s_q.cnt + 3'h1;
                    s_d.oe  = last ? 1'b0 : ~s_q.sh[6];  // free for master ack
                    s_d.st  = last ? D_TXACK : D_TX;
                end
            endcase
        end
    end

    // ==========================================================
    // state and array registers
    always_ff @(negedge link.scl) begin
        if (rst_s_q[1]) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // array contents are not reset, like the real cells
    always_ff @(negedge link.scl) begin
        if (mem_we) begin
            mem[s_q.ctr] <= byte_in;
        end
    end

    assign link.dev_sda_o  = 1'b0;
    assign link.dev_sda_oe = s_q.oe;

endmodule : see_dev

/* verif/see_link_properties.sv */
// checker for the master-to-eeprom link, sampled on the system clock
// assumes the master makes scl from I_CLK, eight cycles a half period
module see_link_properties (
    // system
    input wire logic I_CLK,
    input wire logic I_SYS_RST,
    // link
    input wire logic scl,
    input wire logic host_sda_o,
    input wire logic host_sda_oe,
    input wire logic dev_sda_o,
    input wire logic dev_sda_oe,
    input wire logic sda
);
    timeunit 1ns;
    timeprecision 1ps;

    // ==========================================================
    // framing
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_SYS_RST);
    // data edges while scl stays high; scl is low in reset, so no false hit
    sequence s_start;
        scl && $past(scl) && $fell(sda);
    endsequence
    sequence s_stop;
        scl && $past(scl) && $rose(sda);
    endsequence

    // ==========================================================
    // checks
    a_scl_high_len: assert property ($rose(scl) |-> scl [*8] ##1 !scl)
        else $error("link clock high phase has wrong length");
    a_scl_low_len: assert property ($fell(scl) |-> !scl [*8] ##1 scl)
        else $error("link clock low phase has wrong length");
    a_dev_moves_low: assert property ($changed(dev_sda_oe) |-> !scl)
        else $error("device moved data while clock high");
    a_dev_holds_high: assert property (scl && $past(scl) |-> $stable(dev_sda_oe))
        else $error("device data unstable in high phase");
    a_start_released: assert property (s_start |-> !$past(dev_sda_oe))
        else $error("device held data at start");
    a_stop_released: assert property (s_stop |-> !dev_sda_oe && !$past(dev_sda_oe, 8))
        else $error("device held data at stop");
    a_idle_after_stop: assert property (s_stop |=> !dev_sda_oe [*8])
        else $error("device drove data after stop");
    a_bus_high_after: assert property (s_stop |=> sda [*8])
        else $error("data line not idle after stop");
endmodule : see_link_properties

/* verif/serial_eeprom_read_and_protect_status_tb.sv */
// self-checking bench: master and eeprom end joined by the link
// assumes both ends share I_CLK and its synchronous reset
module serial_eeprom_read_and_protect_status_tb;
    timeunit 1ns;
    timeprecision 1ps;

    // ==========================================================
    // signals
    localparam logic [6:0] LK_PERM = {see_pkg::TYPE_LOCK, 3'h0};
    localparam logic [6:0] LK_SET  = {see_pkg::TYPE_LOCK, see_pkg::SEL_SET_REV};
    localparam logic [6:0] LK_CLR  = {see_pkg::TYPE_LOCK, see_pkg::SEL_CLR_REV};
    localparam logic [2:0] ST_CLR  = {see_pkg::STRAP_CLR_REV, 1'b0};
    logic       clk, rst, req, busy, nack, done, rdv, wp, hv, perm, rev;
    logic [1:0] kind;
    logic [6:0] dev;
    logic [2:0] strap;
    logic [7:0] addr, wdata, count, rdata;
    logic [7:0] rdq[$];
    int         bad_count, samples_checked;

    see_link_if see_link_if_inst ();
    see_host see_host_inst (.I_CLK(clk), .I_SYS_RST(rst), .I_REQ(req), .I_KIND(kind),
        .I_DEV(dev), .I_ADDR(addr), .I_WDATA(wdata), .I_COUNT(count), .O_BUSY(busy),
        .O_NACK(nack), .O_DONE(done), .O_RD_VALID(rdv), .O_RD_DATA(rdata),
        .link(see_link_if_inst));
    see_dev see_dev_inst (.I_CLK(clk), .I_SYS_RST(rst), .I_WP(wp), .I_STRAP(strap),
        .I_HV(hv), .O_PERM_LOCKED(perm), .O_REV_LOCKED(rev), .link(see_link_if_inst));
    see_link_properties see_link_properties_inst (.I_CLK(clk), .I_SYS_RST(rst),
        .scl(see_link_if_inst.scl), .host_sda_o(see_link_if_inst.host_sda_o),
        .host_sda_oe(see_link_if_inst.host_sda_oe), .dev_sda_o(see_link_if_inst.dev_sda_o),
        .dev_sda_oe(see_link_if_inst.dev_sda_oe), .sda(see_link_if_inst.sda));

    // clock, 100 MHz
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // every byte handed back is kept for the scenario to judge
    always @(posedge clk) begin
        if (rdv === 1'b1) rdq.push_back(rdata);
    end

    // ==========================================================
    // helpers
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            $display("Error %s expected %h seen %h", what, exp, seen);
            bad_count++;
        end
    endtask : chk

    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : finish_test

    // one command, then a gap so lock status crosses back
    task automatic cmd(input logic [1:0] k, input logic [6:0] d, input logic [7:0] a,
                       input logic [7:0] w, input logic [7:0] c);
        int n;
        n = 0;
        rdq.delete();
        @(posedge clk);
        req   <= 1'b1;
        kind  <= k;
        dev   <= d;
        addr  <= a;
        wdata <= w;
        count <= c;
        while (busy !== 1'b1 && n < 20) begin
            @(posedge clk);
            #1;
            n++;
        end
        @(posedge clk);
        req <= 1'b0;
        while (done !== 1'b1 && n < 6000) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n >= 6000) chk("done", 8'h00, 8'h01);
        chk("busy", {7'h0, busy}, 8'h00);
        repeat (60) @(posedge clk);
    endtask : cmd

    // device pins pass two scl flops, so wait well past that
    task automatic pins(input logic w, input logic h, input logic [2:0] s);
        @(posedge clk);
        wp    <= w;
        hv    <= h;
        strap <= s;
        repeat (40) @(posedge clk);
    endtask : pins

    task automatic wr(input logic [7:0] a, input logic [7:0] w);
        cmd(see_pkg::K_WRITE, {see_pkg::TYPE_ARRAY, strap}, a, w, 8'h00);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] c);
        cmd(see_pkg::K_RAND, {see_pkg::TYPE_ARRAY, strap}, a, 8'h00, c);
    endtask : rd

    // ==========================================================
    // scenarios
    task automatic t_reads();
        wr(8'h11, 8'hA5);
        chk("wr_ack", {7'h0, nack}, 8'h00);
        wr(8'h10, 8'h5A);
        cmd(see_pkg::K_CUR, {see_pkg::TYPE_ARRAY, strap}, 8'h00, 8'h00, 8'h01);
        chk("cur", rdq[0], 8'hA5);
        rd(8'h10, 8'h02);
        chk("rnd", rdq[0], 8'h5A);
        chk("seq", rdq[1], 8'hA5);
        chk("seq_len", 8'(rdq.size()), 8'h02);
        cmd(see_pkg::K_WRITE, {4'h3, strap}, 8'h10, 8'h00, 8'h00);
        chk("bad_type", {7'h0, nack}, 8'h01);
        wr(8'hFF, 8'hC3);
        wr(8'h00, 8'h3C);
        rd(8'hFF, 8'h02);
        chk("wrap0", rdq[0], 8'hC3);
        chk("wrap1", rdq[1], 8'h3C);
    endtask : t_reads

    // fresh part answers both queries; pin high blocks array writes and both lock sets
    task automatic t_pin();
        chk("rst", {6'h0, perm, rev}, 8'h00);
        cmd(see_pkg::K_CUR, LK_PERM, 8'h00, 8'h00, 8'h00);
        chk("perm_q", {7'h0, nack}, 8'h00);
        pins(1'b0, 1'b1, 3'h0);
        cmd(see_pkg::K_CUR, LK_SET, 8'h00, 8'h00, 8'h00);
        chk("rev_q", {7'h0, nack}, 8'h00);
        pins(1'b1, 1'b0, 3'h0);
        wr(8'h10, 8'h00);
        chk("wp_ack", {7'h0, nack}, 8'h00);
        wr(8'hFF, 8'h00);
        rd(8'hFF, 8'h01);
        chk("wp_top", rdq[0], 8'hC3);
        cmd(see_pkg::K_WRITE, LK_PERM, 8'h00, 8'h00, 8'h00);
        chk("wp_perm", {6'h0, nack, perm}, 8'h00);
        pins(1'b1, 1'b1, 3'h0);
        cmd(see_pkg::K_WRITE, LK_SET, 8'h00, 8'h00, 8'h00);
        chk("wp_rev", {6'h0, nack, rev}, 8'h00);
    endtask : t_pin

    // reversible lock, then permanent lock
    task automatic t_locks();
        pins(1'b0, 1'b1, 3'h0);
        cmd(see_pkg::K_WRITE, LK_SET, 8'h00, 8'h00, 8'h00);
        chk("rev_set", {6'h0, nack, rev}, 8'h01);
        cmd(see_pkg::K_CUR, LK_SET, 8'h00, 8'h00, 8'h00);
        chk("rev_q", {7'h0, nack}, 8'h01);
        cmd(see_pkg::K_WRITE, LK_SET, 8'h00, 8'h00, 8'h00);
        chk("rev_again", {7'h0, nack}, 8'h01);
        pins(1'b0, 1'b0, 3'h0);
        wr(8'h10, 8'h77);
        chk("rev_ack", {7'h0, nack}, 8'h00);
        wr(8'h80, 8'h66);
        rd(8'h10, 8'h01);
        chk("rev_lo", rdq[0], 8'h5A);
        rd(8'h80, 8'h01);
        chk("rev_hi", rdq[0], 8'h66);
        pins(1'b1, 1'b1, ST_CLR);
        cmd(see_pkg::K_WRITE, LK_CLR, 8'h00, 8'h00, 8'h00);
        chk("wp_clr", {6'h0, nack, rev}, 8'h01);
        pins(1'b0, 1'b1, ST_CLR);
        cmd(see_pkg::K_WRITE, LK_CLR, 8'h00, 8'h00, 8'h00);
        chk("clr", {6'h0, nack, rev}, 8'h00);
        pins(1'b0, 1'b0, 3'h0);
        cmd(see_pkg::K_WRITE, LK_PERM, 8'h00, 8'h00, 8'h00);
        chk("perm_set", {6'h0, nack, perm}, 8'h01);
        cmd(see_pkg::K_CUR, LK_PERM, 8'h00, 8'h00, 8'h00);
        chk("perm_q", {7'h0, nack}, 8'h01);
        cmd(see_pkg::K_WRITE, LK_PERM, 8'h00, 8'h00, 8'h00);
        chk("perm_again", {7'h0, nack}, 8'h01);
        pins(1'b0, 1'b1, ST_CLR);
        cmd(see_pkg::K_WRITE, LK_CLR, 8'h00, 8'h00, 8'h00);
        chk("perm_clr", {7'h0, nack}, 8'h01);
        pins(1'b0, 1'b0, 3'h0);
        wr(8'h10, 8'h11);
        rd(8'h10, 8'h01);
        chk("perm_lo", rdq[0], 8'h5A);
    endtask : t_locks

    // ==========================================================
    // main sequence and watchdog
    initial begin
        {rst, req, wp, hv, kind, dev, strap, addr, wdata, count} = {1'b1, 39'h0};
        bad_count = 0;
        samples_checked = 0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        repeat (200) @(posedge clk);
        t_reads();
        t_pin();
        t_locks();
        finish_test();
    end

    // the run needs some 30 commands of under 1500 cycles each
    initial begin
        repeat (90000) @(posedge clk);
        bad_count++;
        finish_test();
    end
endmodule : serial_eeprom_read_and_protect_status_tb
